// *** rtl/spdee_top.sv ***
// spdee_top: two-wire slave front end, block locks and 512-byte array
// assumes an external pull-up on the data line and an avalon-mm master
//
// Chosen here: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module spdee_top #(
   parameter int WRITE_CYCLES = spdee_pkg::WRITE_CYC, // write cycle length
   parameter int TIMEOUT_CYCLES = spdee_pkg::TIMEOUT_CYC // bus-low timeout
) (
   input wire logic clk, // 100 MHz clock
   input wire logic sys_rst, // power-on reset, active high
   input wire logic scl_in, // serial clock pin
   input wire logic sda_in, // serial data pin level
   output logic sda_out, // serial data drive value, always low
   output logic sda_oe_n, // low while pulling data low
   input wire logic slave_addr_pin_0, // address pin 0
   input wire logic slave_addr_pin_1, // address pin 1
   input wire logic slave_addr_pin_2, // address pin 2
   input wire logic high_voltage_level, // high voltage seen on pin 0
   input wire logic write_control_n, // write control, low enables
   input wire logic [3:0] avs_address, // register byte address
   input wire logic avs_read, // read request
   input wire logic avs_write, // write request
   input wire logic [31:0] avs_writedata, // write data
   output logic [31:0] avs_readdata, // read data
   output logic avs_waitrequest // stall
);
   import spdee_pkg::*;
   typedef struct packed {
      spdee_state_e state;
      spdee_state_e nxt;
      spdee_op_e op;
      logic [7:0] sh;
      logic [3:0] cnt;
      logic [7:0] ptr;
      logic page;
      logic [3:0] lock;
      logic [1:0] lblk;
      logic pend;
      logic [7:0] wbyte;
      logic [8:0] waddr;
      logic [31:0] wcnt;
      logic [31:0] tcnt;
      logic oe_n;
      logic scl_q;
      logic sda_q;
      logic en;
      logic ack;
      logic [31:0] rdata;
      logic [511:0][7:0] mem;
   } spdee_top_s;
   spdee_top_s s, next_s;
   logic [6:0] pins;
   logic scl, sda, sa2, sa1, sa0, hv, wc_n;
   logic rise, fall, start, stop, tout, req;
   logic [2:0] sa;
   logic [3:0] cmd;
   logic [1:0] blk;
   logic ok;

   // block number of a protection command, bits 3..1
   function automatic logic [1:0] blk_of(input logic [3:0] c);
      case (c[3:1])
         3'h1: blk_of = 2'h0;
         3'h4: blk_of = 2'h1;
         3'h5: blk_of = 2'h2;
         default: blk_of = 2'h3;
      endcase
   endfunction

   // synchronise every pin input
   spdee_sync #(.W(7)) u_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .d_in({scl_in, sda_in, slave_addr_pin_2, slave_addr_pin_1, slave_addr_pin_0,
             high_voltage_level, write_control_n}),
      .q(pins)
   );
   assign {scl, sda, sa2, sa1, sa0, hv, wc_n} = pins;

   // bus events on the synchronised lines
   assign rise = scl & ~s.scl_q;
   assign fall = ~scl & s.scl_q;
   assign start = scl & s.scl_q & s.sda_q & ~sda;
   assign stop = scl & s.scl_q & ~s.sda_q & sda;
   assign tout = ~scl && s.tcnt >= 32'(TIMEOUT_CYCLES - 1);
   assign sa = {sa2, sa1, sa0};
   assign cmd = s.sh[3:0];
   assign blk = blk_of(cmd);
   assign req = avs_read | avs_write;

   // next-state logic: register port, then serial engine
   always_comb begin
      next_s = s;
      ok = 1'b0;
      next_s.scl_q = scl;
      next_s.sda_q = sda;
      // bus-low timer runs on the system clock
      next_s.tcnt = scl ? 32'h0 : s.tcnt + 32'h1;
      // register port answers on the second edge of a request
      if (req && !s.ack) begin
         next_s.ack = 1'b1;
         next_s.rdata = 32'h0;
         if (avs_address == REG_CTRL) begin
            next_s.rdata[CTRL_EN_BIT] = s.en;
         end else if (avs_address == REG_STATUS) begin
            next_s.rdata[STAT_LOCK_LSB +: 4] = s.lock;
            next_s.rdata[STAT_PAGE_BIT] = s.page;
            next_s.rdata[STAT_BUSY_BIT] = s.state == ST_WRITE;
         end
      end else begin
         next_s.ack = 1'b0;
         // a write lands only at the second edge, where waitrequest is sampled low
         if (avs_write && avs_address == REG_CTRL) begin
            next_s.en = avs_writedata[CTRL_EN_BIT];
         end
      end
      // serial engine
      if (s.state == ST_WRITE) begin
         // internal write cycle, bus ignored
         next_s.wcnt = s.wcnt + 32'h1;
         if (s.wcnt >= 32'(WRITE_CYCLES - 1)) begin
            next_s.state = ST_IDLE;
            next_s.pend = 1'b0;
            case (s.op)
               OP_MEM: next_s.mem[s.waddr] = s.wbyte;
               OP_SET: next_s.lock[s.lblk] = 1'b1;
               default: next_s.lock = 4'h0;
            endcase
         end
      end else if (!s.en) begin
         next_s.state = ST_IDLE;
         next_s.oe_n = 1'b1;
      end else if (stop) begin
         next_s.oe_n = 1'b1;
         // write starts only in the slot right after a data ack; its scl rise is counted
         if (s.pend && s.state == ST_WDATA && s.cnt == 4'h1) begin
            next_s.state = ST_WRITE;
            next_s.wcnt = 32'h0;
         end else begin
            next_s.state = ST_IDLE;
            next_s.pend = 1'b0;
         end
      end else if (start) begin
         next_s.state = ST_DEVSEL;
         next_s.cnt = 4'h0;
         next_s.oe_n = 1'b1;
         next_s.pend = 1'b0;
      end else if (tout && s.state != ST_IDLE) begin
         next_s.state = ST_IDLE;
         next_s.oe_n = 1'b1;
         next_s.pend = 1'b0;
      end else begin
         case (s.state)
            ST_DEVSEL, ST_ADDR, ST_WDATA: begin
               if (rise) begin
                  next_s.sh = {s.sh[6:0], sda};
                  next_s.cnt = s.cnt + 4'h1;
               end else if (fall && s.cnt == 4'h8) begin
                  next_s.cnt = 4'h0;
                  next_s.nxt = ST_IDLE;
                  if (s.state == ST_DEVSEL) begin
                     // device select decode
                     if (s.sh[7:4] == TYPE_MEM && s.sh[3:1] == sa) begin
                        ok = 1'b1;
                        next_s.op = OP_MEM;
                        next_s.nxt = s.sh[0] ? ST_RDATA : ST_ADDR;
                     end else if (s.sh[7:4] == TYPE_PROT) begin
                        if (cmd == CMD_SET_B0 || cmd == CMD_SET_B1 ||
                            cmd == CMD_SET_B2 || cmd == CMD_SET_B3) begin
                           ok = hv;
                           next_s.op = OP_SET;
                           next_s.lblk = blk;
                           next_s.nxt = ST_ADDR;
                        end else if (cmd == CMD_CLEAR) begin
                           ok = hv;
                           next_s.op = OP_CLR;
                           next_s.nxt = ST_ADDR;
                        end else if (cmd == CMD_RD_B0 || cmd == CMD_RD_B1 ||
                                     cmd == CMD_RD_B2 || cmd == CMD_RD_B3) begin
                           ok = !s.lock[blk];
                        end else if (cmd == CMD_PAGE0 || cmd == CMD_PAGE1) begin
                           ok = 1'b1;
                           next_s.page = cmd[1];
                        end else if (cmd == CMD_RD_PAGE) begin
                           ok = !s.page;
                        end
                     end
                  end else if (s.state == ST_ADDR) begin
                     ok = 1'b1;
                     next_s.ptr = s.sh;
                     next_s.nxt = ST_WDATA;
                  end else begin
                     // one data byte per write; locks and write control gate memory bytes only
                     if (s.op == OP_MEM) begin
                        ok = !wc_n && !s.lock[{s.page, s.ptr[7]}] && !s.pend;
                     end else begin
                        ok = !s.pend;
                     end
                     next_s.pend = ok;
                     next_s.wbyte = s.sh;
                     next_s.waddr = {s.page, s.ptr};
                     next_s.nxt = ST_WDATA;
                  end
                  // ack pulls low; a refused code releases and drops off the bus
                  next_s.oe_n = !ok;
                  next_s.state = ok ? ST_ACK : ST_IDLE;
               end
            end
            ST_ACK: begin
               if (fall) begin
                  next_s.state = s.nxt;
                  next_s.oe_n = 1'b1;
                  if (s.nxt == ST_RDATA) begin
                     next_s.sh = s.mem[{s.page, s.ptr}];
                     next_s.oe_n = s.mem[{s.page, s.ptr}][7];
                  end
               end
            end
            ST_RDATA: begin
               if (rise) begin
                  next_s.cnt = s.cnt + 4'h1;
               end else if (fall && s.cnt == 4'h8) begin
                  next_s.oe_n = 1'b1;
                  next_s.cnt = 4'h0;
                  next_s.state = ST_RACK;
               end else if (fall) begin
                  next_s.sh = {s.sh[6:0], 1'b0};
                  next_s.oe_n = s.sh[6];
               end
            end
            ST_RACK: begin
               // master no-ack ends the read
               if (rise && sda) begin
                  next_s.state = ST_IDLE;
               end else if (fall) begin
                  next_s.ptr = s.ptr + 8'h1;
                  next_s.sh = s.mem[{s.page, s.ptr + 8'h1}];
                  next_s.oe_n = s.mem[{s.page, s.ptr + 8'h1}][7];
                  next_s.state = ST_RDATA;
               end
            end
            default: begin
               next_s.oe_n = 1'b1;
            end
         endcase
      end
   end

   // state register; reset holds the bus released
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s <= '0;
         s.state <= ST_IDLE;
         s.op <= OP_MEM;
         s.nxt <= ST_IDLE;
         s.oe_n <= 1'b1;
         s.scl_q <= 1'b1;
         s.sda_q <= 1'b1;
         s.en <= CTRL_EN_RST;
         s.mem <= {512{MEM_RST}};
      end else begin
         s <= next_s;
      end
   end

   // outputs
   assign sda_out = 1'b0;
   assign sda_oe_n = s.oe_n;
   assign avs_waitrequest = req & ~s.ack;
   assign avs_readdata = s.rdata;

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence s_write_arm;
      s.pend && s.state == ST_WDATA && s.cnt == 4'h1 && s.en;
   endsequence
   sequence s_stop_seen;
      stop;
   endsequence
   sequence s_devsel_end;
      s.state == ST_DEVSEL && fall && s.cnt == 4'h8 && s.en && !stop && !start && !tout;
   endsequence

   property p_por;
      @(posedge clk) disable iff (1'b0) $past(sys_rst) |-> sda_oe_n && s.state == ST_IDLE;
   endproperty
   a_por: assert property (p_por) else $error("bus not idle after reset");
   property p_write_start;
      s_write_arm ##0 s_stop_seen |=> s.state == ST_WRITE ##1 s.wcnt == 32'h1;
   endproperty
   a_write_start: assert property (p_write_start) else $error("stop did not start write");
   property p_write_deaf;
      s.state == ST_WRITE && s.wcnt < 32'(WRITE_CYCLES - 1) |=> s.state == ST_WRITE && sda_oe_n;
   endproperty
   a_write_deaf: assert property (p_write_deaf) else $error("bus answered during write");
   property p_match_ack;
      s_devsel_end ##0 (s.sh[7:4] == TYPE_MEM && s.sh[3:1] == sa) |=> !sda_oe_n;
   endproperty
   a_match_ack: assert property (p_match_ack) else $error("matching select not acked");
   property p_mismatch;
      s_devsel_end ##0 (s.sh[7:4] == TYPE_MEM && s.sh[3:1] != sa)
         |=> sda_oe_n && s.state == ST_IDLE;
   endproperty
   a_mismatch: assert property (p_mismatch) else $error("foreign select acked");
   property p_lock_hv;
      s_devsel_end ##0 (s.sh[7:4] == TYPE_PROT && cmd == CMD_CLEAR && !hv) |=> sda_oe_n;
   endproperty
   a_lock_hv: assert property (p_lock_hv) else $error("clear accepted without high voltage");
   property p_clear_all;
      s.state == ST_WRITE && s.op == OP_CLR && s.wcnt >= 32'(WRITE_CYCLES - 1) |=> s.lock == 4'h0;
   endproperty
   a_clear_all: assert property (p_clear_all) else $error("locks not all cleared");
   property p_lock_change;
      s.lock != $past(s.lock) |-> $past(s.state) == ST_WRITE;
   endproperty
   a_lock_change: assert property (p_lock_change) else $error("lock changed outside write");
   property p_wc;
      s.state == ST_WDATA && fall && s.cnt == 4'h8 && s.op == OP_MEM && wc_n && s.en
         && !stop && !start && !tout |=> sda_oe_n && !s.pend;
   endproperty
   a_wc: assert property (p_wc) else $error("write accepted with write control high");
   property p_timeout;
      tout && s.en && s.state != ST_WRITE && !stop && !start |=> s.state == ST_IDLE && sda_oe_n;
   endproperty
   a_timeout: assert property (p_timeout) else $error("timeout ignored");
   property p_avs;
      req && avs_waitrequest |=> !avs_waitrequest ##1 !req || avs_waitrequest;
   endproperty
   a_avs: assert property (p_avs) else $error("register port answer late");
endmodule // spdee_top

// *** rtl/spdee_pkg.sv ***
// spdee_pkg: constants, codes and types of the presence-detect eeprom slave
// assumes a 100 MHz system clock and a 32-bit avalon-mm register port
// Contract
// - 512 bytes, two 256-byte pages, 128-byte blocks
// - separate write lock for each of four blocks
// - locks persist (here sys_rst clears them); set and clear need high voltage
// - clearing command unlocks all four blocks together
// - page select reuses legacy commands on either page
// - long scl low abandons transfer, back to standby
// - data line only pulled low or released
// - address pins compared with type code bits 3..1
// - unconnected address pin reads as zero
// - high voltage sensed when decoding lock commands
// - write control high rejects all memory writes
// - write control low leaves decision to locks
// - bus ignored while power-on reset held
// - reset release initialises state, enters standby
// - reset asserting again stops all bus answers
// - stop enters standby when no write cycle runs
// - device is always slave, master drives clock
// - type 1010 memory, 0110 protection settings
// - stop after write data starts write cycle
// - write cycle ignores bus, answers nothing
package spdee_pkg;
   // register map (byte addresses)
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam int CTRL_EN_BIT = 0;
   localparam int STAT_LOCK_LSB = 0;
   localparam int STAT_PAGE_BIT = 4;
   localparam int STAT_BUSY_BIT = 5;
   localparam logic CTRL_EN_RST = 1'b1;
   localparam logic [7:0] MEM_RST = 8'hff;
   // timing
   localparam int CLK_MHZ = 100;
   localparam int WRITE_TIME_US = 5000;
   localparam int WRITE_CYC = WRITE_TIME_US * CLK_MHZ;
   localparam int TIMEOUT_US = 25000;
   localparam int TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;
   // device type codes and protection commands (bits 3..0)
   localparam logic [3:0] TYPE_MEM = 4'ha;
   localparam logic [3:0] TYPE_PROT = 4'h6;
   localparam logic [3:0] CMD_SET_B0 = 4'h2;
   localparam logic [3:0] CMD_SET_B1 = 4'h8;
   localparam logic [3:0] CMD_SET_B2 = 4'ha;
   localparam logic [3:0] CMD_SET_B3 = 4'h0;
   localparam logic [3:0] CMD_CLEAR = 4'h6;
   localparam logic [3:0] CMD_RD_B0 = 4'h3;
   localparam logic [3:0] CMD_RD_B1 = 4'h9;
   localparam logic [3:0] CMD_RD_B2 = 4'hb;
   localparam logic [3:0] CMD_RD_B3 = 4'h1;
   localparam logic [3:0] CMD_PAGE0 = 4'hc;
   localparam logic [3:0] CMD_PAGE1 = 4'he;
   localparam logic [3:0] CMD_RD_PAGE = 4'hd;
   typedef enum logic [3:0] {
      ST_IDLE, ST_DEVSEL, ST_ADDR, ST_WDATA, ST_ACK, ST_RDATA, ST_RACK, ST_WRITE
   } spdee_state_e;
   typedef enum logic [1:0] {OP_MEM, OP_SET, OP_CLR} spdee_op_e;
endpackage

// *** rtl/spdee_sync.sv ***
// spdee_sync: two-flop synchroniser bank for the pin inputs
// assumes inputs are asynchronous to clk; reset drives outputs high (idle bus)
`timescale 1ns/1ns
module spdee_sync #(
   parameter int W = 7
) (
   input wire logic clk, // system clock
   input wire logic sys_rst, // synchronous reset, active high
   input wire logic [W-1:0] d_in, // asynchronous pin levels
   output logic [W-1:0] q // synchronised levels
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } spdee_sync_s;
   spdee_sync_s s, next_s;
   genvar i;
   // first stage feeds only the second stage
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_comb begin
            next_s.s1[i] = d_in[i];
            next_s.s2[i] = s.s1[i];
         end
      end
   endgenerate
   // register both stages
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s <= '1;
      end else begin
         s <= next_s;
      end
   end
   assign q = s.s2;
endmodule // spdee_sync

// *** sim/spdee_bus_master.sv ***
// spdee_bus_master: behavioural two-wire bus master for the eeprom slave
// assumes a pull-up on the data line; scl period is 16 clk, high when idle
`timescale 1ns/1ns
module spdee_bus_master (
   input wire logic clk, // system clock
   input wire logic sda_line, // resolved data line
   output logic scl, // serial clock, stands high between frames
   output logic sda_rel // 1 releases the data line, 0 pulls it low
);
   // idle bus at time zero
   initial begin
      scl = 1'b1;
      sda_rel = 1'b1;
   end
   // wait n clock edges
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // one bit: data set while scl low, sampled mid high phase
   task automatic bit_io(input logic b, output logic r);
      sda_rel <= b;
      tick(4);
      scl <= 1'b1;
      tick(4);
      r = sda_line;
      tick(4);
      scl <= 1'b0;
      tick(4);
   endtask
   // start: data falls while scl high
   task automatic start();
      sda_rel <= 1'b1;
      tick(4);
      scl <= 1'b1;
      tick(4);
      sda_rel <= 1'b0;
      tick(4);
      scl <= 1'b0;
      tick(4);
   endtask
   // stop: data rises while scl high, bus left idle
   task automatic stop();
      sda_rel <= 1'b0;
      tick(4);
      scl <= 1'b1;
      tick(4);
      sda_rel <= 1'b1;
      tick(8);
   endtask
   // byte out msb first, ack sampled on the ninth clock
   task automatic send_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = (r === 1'b0);
   endtask
   // byte in msb first, nack bit driven on the ninth clock
   task automatic recv_byte(input logic nack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(nack, r);
   endtask
endmodule // spdee_bus_master

// *** sim/spd_eeprom_serial_slave_test.sv ***
// spd_eeprom_serial_slave_test: self-checking bench for the eeprom slave
// assumes shortened write and timeout counts and a pulled-up data line
`timescale 1ns/1ns
module spd_eeprom_serial_slave_test;
   import spdee_pkg::*;
   localparam int WCYC = 400;
   localparam int TCYC = 200;
   localparam logic [7:0] SEL_W = {TYPE_MEM, 3'b101, 1'b0};
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic hv = 1'b0;
   logic wc_n = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic sda_out;
   logic sda_oe_n;
   logic scl;
   logic sda_rel;
   logic sda_line;
   int miscompares = 0;
   int num_checks = 0;
   // 100 MHz clock
   always #5 clk = ~clk;
   // wired data line with pull-up
   assign sda_line = sda_rel & ((sda_oe_n === 1'b0) ? sda_out : 1'b1);
   spdee_top #(.WRITE_CYCLES(WCYC), .TIMEOUT_CYCLES(TCYC)) spdee_top_inst (
      .clk(clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n), .slave_addr_pin_0(1'b1),
      .slave_addr_pin_1(1'b0), .slave_addr_pin_2(1'b1), .high_voltage_level(hv),
      .write_control_n(wc_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
   spdee_bus_master mst (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_rel(sda_rel));
   task automatic report_and_stop();
      if (miscompares == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         miscompares++;
      end
   endtask
   // one avalon access, held until waitrequest is sampled low
   task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
      int n;
      n = 0;
      avs_address <= a;
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= wd;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 20) begin
         miscompares++;
         report_and_stop();
      end
      @(posedge clk);
   endtask
   // poll status until the write cycle is over
   task automatic wait_idle();
      logic [31:0] s;
      int n;
      n = 0;
      do begin
         av(1'b0, REG_STATUS, 32'h0, s);
         n++;
      end while (s[STAT_BUSY_BIT] !== 1'b0 && n < 400);
      if (n >= 400) begin
         miscompares++;
         report_and_stop();
      end
   endtask
   // select, optional address and data byte, then stop
   task automatic xfer(input logic [7:0] sel, input logic [7:0] a, input logic [7:0] d,
                       input int n, output logic [2:0] ak);
      ak = 3'b000;
      mst.start();
      mst.send_byte(sel, ak[2]);
      if (n > 1) mst.send_byte(a, ak[1]);
      if (n > 2) mst.send_byte(d, ak[0]);
      mst.stop();
   endtask
   // random read of one byte from the current page
   task automatic rd_mem(input logic [7:0] a, output logic [7:0] d);
      logic [2:0] ak;
      mst.start();
      mst.send_byte(SEL_W, ak[2]);
      mst.send_byte(a, ak[1]);
      mst.start();
      mst.send_byte(SEL_W | 8'h01, ak[0]);
      mst.recv_byte(1'b1, d);
      mst.stop();
      chk(32'(ak), 32'h7);
   endtask
   task automatic t_regs();
      logic [31:0] s;
      logic [7:0] d;
      logic [2:0] ak;
      av(1'b0, REG_CTRL, 32'h0, s);
      chk(s, 32'h1);
      av(1'b0, REG_STATUS, 32'h0, s);
      chk(s, 32'h0);
      av(1'b1, 4'h8, 32'hffff_ffff, s);
      av(1'b0, 4'h8, 32'h0, s);
      chk(s, 32'h0);
      rd_mem(8'h00, d);
      chk(32'(d), 32'hff);
      av(1'b1, REG_CTRL, 32'h0, s);
      xfer(SEL_W, 8'h00, 8'h00, 1, ak);
      chk(32'(ak), 32'h0);
      av(1'b1, REG_CTRL, 32'h1, s);
   endtask
   task automatic t_write();
      logic [2:0] ak;
      logic [31:0] s;
      logic [7:0] d;
      xfer(SEL_W, 8'h10, 8'h5a, 3, ak);
      chk(32'(ak), 32'h7);
      av(1'b0, REG_STATUS, 32'h0, s);
      chk(32'(s[STAT_BUSY_BIT]), 32'h1);
      xfer(SEL_W, 8'h10, 8'h00, 1, ak);
      chk(32'(ak), 32'h0);
      wait_idle();
      rd_mem(8'h10, d);
      chk(32'(d), 32'h5a);
      for (int i = 1; i < 4; i++) begin
         xfer(SEL_W ^ (8'h01 << i), 8'h00, 8'h00, 1, ak);
         chk(32'(ak), 32'h0);
      end
      wc_n <= 1'b1;
      xfer(SEL_W, 8'h20, 8'h11, 3, ak);
      chk(32'(ak), 32'h6);
      wc_n <= 1'b0;
      rd_mem(8'h20, d);
      chk(32'(d), 32'hff);
   endtask
   task automatic t_locks();
      logic [2:0] ak;
      logic [31:0] s;
      xfer({TYPE_PROT, CMD_SET_B0}, 8'h00, 8'h00, 1, ak);
      chk(32'(ak), 32'h0);
      xfer({TYPE_PROT, CMD_CLEAR}, 8'h00, 8'h00, 1, ak);
      chk(32'(ak), 32'h0);
      hv <= 1'b1;
      xfer({TYPE_PROT, CMD_SET_B0}, 8'h00, 8'h00, 3, ak);
      chk(32'(ak), 32'h7);
      wait_idle();
      xfer({TYPE_PROT, CMD_SET_B3}, 8'h00, 8'h00, 3, ak);
      chk(32'(ak), 32'h7);
      wait_idle();
      hv <= 1'b0;
      av(1'b0, REG_STATUS, 32'h0, s);
      chk(s, 32'h9);
      xfer(SEL_W, 8'h10, 8'h77, 3, ak);
      chk(32'(ak), 32'h6);
      xfer({TYPE_PROT, CMD_RD_B0}, 8'h00, 8'h00, 1, ak);
      chk(32'(ak), 32'h0);
      xfer({TYPE_PROT, CMD_RD_B1}, 8'h00, 8'h00, 1, ak);
      chk(32'(ak), 32'h4);
      xfer({TYPE_PROT, CMD_RD_B3}, 8'h00, 8'h00, 1, ak);
      chk(32'(ak), 32'h0);
      hv <= 1'b1;
      xfer({TYPE_PROT, CMD_CLEAR}, 8'h00, 8'h00, 3, ak);
      wait_idle();
      hv <= 1'b0;
      av(1'b0, REG_STATUS, 32'h0, s);
      chk(s, 32'h0);
   endtask
   task automatic t_page();
      logic [2:0] ak;
      logic [31:0] s;
      logic [7:0] d;
      xfer({TYPE_PROT, CMD_PAGE1}, 8'h00, 8'h00, 1, ak);
      chk(32'(ak), 32'h4);
      av(1'b0, REG_STATUS, 32'h0, s);
      chk(32'(s[STAT_PAGE_BIT]), 32'h1);
      xfer({TYPE_PROT, CMD_RD_PAGE}, 8'h00, 8'h00, 1, ak);
      chk(32'(ak), 32'h0);
      xfer(SEL_W, 8'h10, 8'hc3, 3, ak);
      wait_idle();
      rd_mem(8'h10, d);
      chk(32'(d), 32'hc3);
      xfer({TYPE_PROT, CMD_PAGE0}, 8'h00, 8'h00, 1, ak);
      rd_mem(8'h10, d);
      chk(32'(d), 32'h5a);
   endtask
   task automatic t_timeout_reset();
      logic r;
      logic [7:0] d;
      logic [2:0] ak;
      mst.start();
      for (int i = 7; i > 0; i--) mst.bit_io(SEL_W[i] | (i == 0), r);
      mst.tick(TCYC + 100);
      mst.recv_byte(1'b1, d);
      chk(32'(d), 32'hff);
      mst.stop();
      xfer(SEL_W, 8'h00, 8'h00, 1, ak);
      chk(32'(ak), 32'h4);
      mst.start();
      mst.send_byte(SEL_W, r);
      sys_rst <= 1'b1;
      mst.send_byte(8'h10, r);
      chk(32'(r), 32'h0);
      chk(32'(sda_oe_n), 32'h1);
      mst.stop();
      xfer(SEL_W, 8'h00, 8'h00, 1, ak);
      chk(32'(ak), 32'h0);
      sys_rst <= 1'b0;
      mst.tick(4);
      rd_mem(8'h10, d);
      chk(32'(d), 32'hff);
   endtask
   // the device may only pull the data line low
   always @(posedge clk) begin
      if (sda_oe_n === 1'b0) chk(32'(sda_out), 32'h0);
   end
   // reset, then the scenarios in turn
   initial begin
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge clk);
      t_regs();
      t_write();
      t_locks();
      t_page();
      t_timeout_reset();
      report_and_stop();
   end
endmodule // spd_eeprom_serial_slave_test
